// >>> design/adcpf_pkg.sv
/*
  Constants, register map and types for the converter control block.
  Assumes an 8-bit internal bus with 16-bit byte addresses.
*/
package adcpf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [15:0] ADDR_MODE      = 16'hFF98;
  localparam logic [15:0] ADDR_CHAN      = 16'hFF99;
  localparam logic [15:0] ADDR_CMP_MODE  = 16'hFF9A;
  localparam logic [15:0] ADDR_THRESHOLD = 16'hFF9B;
  localparam logic [15:0] ADDR_RESULT    = 16'hFF9F;

  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int RUN_BIT      = 7;
  localparam int TSEL_HI      = 5;
  localparam int TSEL_LO      = 3;
  localparam int CHAN_HI      = 2;
  localparam int CMP_EN_BIT   = 7;
  localparam int CMP_POL_BIT  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing in main clock cycles
  localparam logic [2:0] TSEL_144 = 3'h0;
  localparam logic [2:0] TSEL_120 = 3'h1;
  localparam logic [2:0] TSEL_96  = 3'h2;
  localparam logic [2:0] TSEL_288 = 3'h4;
  localparam logic [2:0] TSEL_240 = 3'h5;
  localparam logic [2:0] TSEL_192 = 3'h6;

  localparam int CONV_CYC_144 = 144;
  localparam int CONV_CYC_120 = 120;
  localparam int CONV_CYC_96  = 96;
  localparam int CONV_CYC_288 = 288;
  localparam int CONV_CYC_240 = 240;
  localparam int CONV_CYC_192 = 192;

  // Conversion split into equal units: sampling units then one per bit
  localparam int            UNITS_PER_CONV = 12;
  localparam int            SAMPLE_UNITS   = 4;
  localparam logic [3:0]    STEP_SAMPLE_LAST = 4'(SAMPLE_UNITS - 1);
  localparam logic [3:0]    STEP_LAST        = 4'(UNITS_PER_CONV - 1);
  localparam logic [3:0]    STEP_ZERO        = 4'h0;
  localparam logic [4:0]    CYC_ZERO         = 5'h00;
  localparam logic [7:0]    SAR_MSB_TRIAL    = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } adcpf_state_t;

  // Cycles per unit for a time select code; prohibited codes run as 144
  function automatic logic [4:0] adcpf_unit_len(input logic [2:0] tsel);
    logic [4:0] len;
    len = 5'(CONV_CYC_144 / UNITS_PER_CONV);
    case (tsel)
      TSEL_120: len = 5'(CONV_CYC_120 / UNITS_PER_CONV);
      TSEL_96:  len = 5'(CONV_CYC_96  / UNITS_PER_CONV);
      TSEL_288: len = 5'(CONV_CYC_288 / UNITS_PER_CONV);
      TSEL_240: len = 5'(CONV_CYC_240 / UNITS_PER_CONV);
      TSEL_192: len = 5'(CONV_CYC_192 / UNITS_PER_CONV);
      default:  len = 5'(CONV_CYC_144 / UNITS_PER_CONV);
    endcase
    return len;
  endfunction

endpackage

// >>> design/adcpf_core.sv
/*
  Control logic of an 8-bit successive-approximation converter with five
  inputs and a threshold comparator for power-fail detection.
  Assumes an analog front end: channel mux, sample-and-hold, a tap voltage
  set by the trial code and a comparator whose decision arrives unsynchronised.
*/
`timescale 1ns/1ps

// What this block does
// RQ1: Time code selects 96..288 cycle conversion length
// RQ2: Software keeps conversion time at least 14us
// RQ3: Software writes zero to mode bits 0-2,6
// RQ4: Channel codes 0-4 select analog inputs 0-4
// RQ5: Compare enable bit picks plain or compare
// RQ6: Polarity: irq on >= threshold or < threshold
// RQ7: Software zeroes compare bits 0-5; reset clears
// RQ8: Writable 8-bit threshold, reset to zero
// RQ9: Sample fixed period, then hold until done
// RQ10: After eight steps latch result, raise irq
// RQ11: First result after start is undefined
// RQ12: Conversions repeat back to back while running
// RQ13: Mode or channel write restarts conversion
// RQ14: Run bit cleared stops conversion immediately
// RQ15: Reset clears result, mode and channel registers
// RQ16: Compare off: every conversion raises the irq
// RQ17: Compare on: first conversion irq suppressed
// RQ18: Result read wins over simultaneous update
// RQ19: Mode or channel write at conversion end drops update, irq
// RQ20: One bit per step, most significant first
// RQ21: Done irq is a single-clock pulse
module adcpf_core
  import adcpf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // Internal bus
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  // Analog front end
  input  wire logic        cmp_in,
  output logic      [2:0]  channel_sel,
  output logic             sample_en,
  output logic      [7:0]  dac_trial_code,
  output logic             conv_active,
  // Interrupt
  output logic             conversion_done_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]   conversion_mode_reg;
  logic [7:0]   input_select_reg;
  logic [7:0]   compare_mode_reg;
  logic [7:0]   compare_threshold;
  logic [7:0]   conversion_result;
  logic [7:0]   successive_approx_reg;
  adcpf_state_t state_reg;
  logic [3:0]   step_reg;
  logic [4:0]   cyc_reg;
  logic         first_reg;
  logic         cmp_s1_reg;
  logic         cmp_s2_reg;
  logic         cmp_s3_reg;
  logic         cmp_reg;
  logic         mode_wr;
  logic         chan_wr;
  logic         thr_wr;
  logic         cmpm_wr;
  logic         restart;
  logic         run_next;
  logic [4:0]   unit_len;
  logic         unit_end;
  logic [2:0]   bit_pos;
  logic         conv_done;
  logic [7:0]   result_next;
  logic         cmp_hit;
  logic         irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign mode_wr  = bus_wr && (bus_addr == ADDR_MODE);
  assign chan_wr  = bus_wr && (bus_addr == ADDR_CHAN);
  assign cmpm_wr  = bus_wr && (bus_addr == ADDR_CMP_MODE);
  assign thr_wr   = bus_wr && (bus_addr == ADDR_THRESHOLD);
  assign restart  = mode_wr || chan_wr;                                    // [RQ13]
  assign run_next = mode_wr ? bus_wdata[RUN_BIT] : conversion_mode_reg[RUN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conversion_mode_reg <= REG_RESET;                                    // [RQ15]
      input_select_reg    <= REG_RESET;                                    // [RQ15]
      compare_mode_reg    <= REG_RESET;                                    // [RQ7]
      compare_threshold   <= REG_RESET;                                    // [RQ8]
    end else if (clk_en) begin
      if (mode_wr) begin
        conversion_mode_reg <= bus_wdata;
      end
      if (chan_wr) begin
        input_select_reg <= bus_wdata;
      end
      if (cmpm_wr) begin
        compare_mode_reg <= bus_wdata;
      end
      if (thr_wr) begin
        compare_threshold <= bus_wdata;                                    // [RQ8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator decision synchroniser
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      cmp_s3_reg <= 1'b0;
      cmp_reg    <= 1'b0;
    end else if (clk_en) begin
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      if (cmp_s2_reg == cmp_s3_reg) begin
        cmp_reg <= cmp_s3_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step timing
  assign unit_len    = adcpf_unit_len(conversion_mode_reg[TSEL_HI:TSEL_LO]); // [RQ1]
  assign unit_end    = (cyc_reg == unit_len - 5'h01);
  assign bit_pos     = 3'(STEP_LAST - step_reg);                            // [RQ20]
  assign conv_done   = (state_reg == ST_CONVERT) && unit_end && (step_reg == STEP_LAST);
  assign result_next = {successive_approx_reg[7:1], cmp_reg};
  assign cmp_hit     = compare_mode_reg[CMP_POL_BIT] ?
                       (result_next <  compare_threshold) :
                       (result_next >= compare_threshold);                  // [RQ6]
  assign irq_next    = !compare_mode_reg[CMP_EN_BIT] ||                     // [RQ5] [RQ16]
                       (cmp_hit && !first_reg);                             // [RQ17]

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg             <= ST_IDLE;
      step_reg              <= STEP_ZERO;
      cyc_reg               <= CYC_ZERO;
      successive_approx_reg <= REG_RESET;
      sample_en             <= 1'b0;
      conv_active           <= 1'b0;
      first_reg             <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        step_reg              <= STEP_ZERO;
        cyc_reg               <= CYC_ZERO;
        successive_approx_reg <= REG_RESET;
        if (run_next) begin
          state_reg   <= ST_SAMPLE;                                        // [RQ13]
          sample_en   <= 1'b1;
          conv_active <= 1'b1;
          if (mode_wr && !conversion_mode_reg[RUN_BIT]) begin
            first_reg <= 1'b1;                                             // [RQ11]
          end
        end else begin
          state_reg   <= ST_IDLE;                                          // [RQ14]
          sample_en   <= 1'b0;
          conv_active <= 1'b0;
        end
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            cyc_reg <= CYC_ZERO;
          end
          ST_SAMPLE: begin
            if (unit_end) begin
              cyc_reg  <= CYC_ZERO;
              step_reg <= step_reg + 4'h1;
              if (step_reg == STEP_SAMPLE_LAST) begin
                state_reg             <= ST_CONVERT;                       // [RQ9]
                sample_en             <= 1'b0;                             // [RQ9]
                successive_approx_reg <= SAR_MSB_TRIAL;                    // [RQ20]
              end
            end else begin
              cyc_reg <= cyc_reg + 5'h01;
            end
          end
          ST_CONVERT: begin
            if (unit_end) begin
              cyc_reg <= CYC_ZERO;
              successive_approx_reg[bit_pos] <= cmp_reg;                   // [RQ20]
              if (step_reg == STEP_LAST) begin
                state_reg <= ST_SAMPLE;                                    // [RQ12]
                sample_en <= 1'b1;
                step_reg  <= STEP_ZERO;
                first_reg <= 1'b0;
              end else begin
                step_reg <= step_reg + 4'h1;
                successive_approx_reg[bit_pos - 3'h1] <= 1'b1;             // [RQ20]
              end
            end else begin
              cyc_reg <= cyc_reg + 5'h01;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result latch and interrupt pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conversion_result   <= REG_RESET;                                    // [RQ15]
      conversion_done_irq <= 1'b0;
    end else if (clk_en) begin
      conversion_done_irq <= 1'b0;                                         // [RQ21]
      if (conv_done && !restart) begin                                     // [RQ19]
        conversion_result   <= result_next;                                // [RQ10]
        conversion_done_irq <= irq_next;                                   // [RQ10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back; a read sees the value held before any same-cycle update
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= REG_RESET;
    end else if (clk_en && bus_rd) begin
      unique case (bus_addr)
        ADDR_MODE:      bus_rdata <= conversion_mode_reg;
        ADDR_CHAN:      bus_rdata <= input_select_reg;
        ADDR_CMP_MODE:  bus_rdata <= compare_mode_reg;
        ADDR_THRESHOLD: bus_rdata <= compare_threshold;
        ADDR_RESULT:    bus_rdata <= conversion_result;                    // [RQ18]
        default:        bus_rdata <= RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      channel_sel <= 3'h0;
    end else if (clk_en) begin
      channel_sel <= input_select_reg[CHAN_HI:0];                          // [RQ4]
    end
  end

  assign dac_trial_code = successive_approx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  irq_single_pulse_a: assert property (clk_en && conversion_done_irq |=> !conversion_done_irq) // [RQ21]
    else $error("Done irq longer than one cycle");
  stop_on_clear_a: assert property (clk_en && mode_wr && !bus_wdata[RUN_BIT] |=>   // [RQ14]
      state_reg == ST_IDLE && !conv_active)
    else $error("Conversion did not stop on run clear");
  restart_on_write_a: assert property (clk_en && restart && run_next |=>         // [RQ13]
      state_reg == ST_SAMPLE && step_reg == STEP_ZERO && cyc_reg == CYC_ZERO)
    else $error("Conversion did not restart on write");
  collide_no_irq_a: assert property (clk_en && restart |=>                       // [RQ19]
      !conversion_done_irq && $stable(conversion_result))
    else $error("Result or irq after colliding write");
  result_latch_a: assert property (clk_en && conv_done && !restart |=>           // [RQ10]
      conversion_result == $past(result_next))
    else $error("Result not latched at conversion end");
  plain_irq_a: assert property (clk_en && conv_done && !restart &&               // [RQ16]
      !compare_mode_reg[CMP_EN_BIT] |=> conversion_done_irq)
    else $error("Plain mode missed done irq");
  first_suppress_a: assert property (clk_en && conv_done && first_reg &&         // [RQ17]
      compare_mode_reg[CMP_EN_BIT] |=> !conversion_done_irq)
    else $error("First compare conversion raised irq");
  polarity_a: assert property (clk_en && conv_done && !restart && !first_reg &&  // [RQ6]
      compare_mode_reg[CMP_EN_BIT] |=> conversion_done_irq ==
      ($past(compare_mode_reg[CMP_POL_BIT]) ?
       (conversion_result <  $past(compare_threshold)) :
       (conversion_result >= $past(compare_threshold))))
    else $error("Compare gating wrong for polarity");
  hold_phase_a: assert property (state_reg == ST_CONVERT |-> !sample_en &&       // [RQ9]
      step_reg >= SAMPLE_UNITS[3:0])
    else $error("Sampling during bit steps");
  unit_bound_a: assert property (cyc_reg < unit_len || restart)                  // [RQ1]
    else $error("Step counter past unit length");
  threshold_wr_a: assert property (clk_en && thr_wr |=>                          // [RQ8]
      compare_threshold == $past(bus_wdata))
    else $error("Threshold write lost");
  read_first_a: assert property (clk_en && bus_rd && bus_addr == ADDR_RESULT |=> // [RQ18]
      bus_rdata == $past(conversion_result))
    else $error("Result read not served first");
  continuous_a: assert property (clk_en && conv_done && !restart |=>             // [RQ12]
      state_reg == ST_SAMPLE && sample_en)
    else $error("No follow-on conversion");

  plain_done_c:   cover property (conversion_done_irq && !compare_mode_reg[CMP_EN_BIT]);
  compare_hit_c:  cover property (conversion_done_irq && compare_mode_reg[CMP_EN_BIT]);
  abort_write_c:  cover property (clk_en && restart && state_reg == ST_CONVERT);
  collide_end_c:  cover property (clk_en && restart && conv_done);

endmodule

// >>> testbench/adcpf_analog_model.sv
/*
  Behavioural analog front end: channel mux, sample-and-hold and comparator.
  Assumes the bench gives five 8-bit input levels, channel 0 in the low byte.
*/
`timescale 1ns/1ps
module adcpf_analog_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Converter side
  input  wire logic [2:0]  channel_sel,
  input  wire logic        sample_en,
  input  wire logic [7:0]  dac_trial_code,
  output logic             cmp_in,
  // Bench side
  input  wire logic [39:0] levels
);
  logic [7:0] held_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Track input while sampling, hold it otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      held_reg <= 8'h00;
    end else if (sample_en) begin
      held_reg <= (channel_sel < 3'h5) ? levels[{channel_sel, 3'b000} +: 8] : 8'h00;
    end
  end

  // Decision for the current trial tap
  assign cmp_in = (held_reg >= dac_trial_code);
endmodule

// >>> testbench/adc_control_power_fail_compare_tb.sv
/*
  Self-checking bench for the converter control block.
  Assumes the analog model beside it and the clock enable held high.
*/
`timescale 1ns/1ps
module adc_control_power_fail_compare_tb;
  import adcpf_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        nrst        = 1'b0;
  logic [15:0] bus_addr    = 16'h0000;
  logic        bus_wr      = 1'b0;
  logic        bus_rd      = 1'b0;
  logic [7:0]  bus_wdata   = 8'h00;
  logic [7:0]  bus_rdata;
  logic        cmp_in;
  logic [2:0]  channel_sel;
  logic        sample_en;
  logic [7:0]  trial;
  logic        conv_active;
  logic        irq;
  logic [39:0] levels      = 40'hA5_01_FF_3C_80;
  int          num_errors  = 0;
  int          check_count = 0;
  logic [7:0]  rd;
  logic [15:0] n;
  int          lens [6]    = '{CONV_CYC_144, CONV_CYC_120, CONV_CYC_96,
                               CONV_CYC_288, CONV_CYC_240, CONV_CYC_192};
  logic [2:0]  codes [6]   = '{TSEL_144, TSEL_120, TSEL_96, TSEL_288, TSEL_240, TSEL_192};

  always #25 sys_clk = ~sys_clk;

  adcpf_core dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .cmp_in(cmp_in), .channel_sel(channel_sel), .sample_en(sample_en),
    .dac_trial_code(trial), .conv_active(conv_active), .conversion_done_irq(irq));

  adcpf_analog_model model_u (.sys_clk(sys_clk), .nrst(nrst), .channel_sel(channel_sel),
    .sample_en(sample_en), .dac_trial_code(trial), .cmp_in(cmp_in), .levels(levels));

  ////////////////////////////////////////////////////////////////////////////
  // Bus and check tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic rdreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    @(posedge sys_clk);
    d = bus_rdata;
  endtask

  // Cycles until the next done pulse
  task automatic wait_irq(output logic [15:0] cnt);
    cnt = 16'h0000;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > 16'd1000) begin
        num_errors++;
        results();
      end
    end while (irq !== 1'b1);
  endtask

  // Done pulses seen over a window
  task automatic count_irq(input int cycles, output logic [15:0] cnt);
    cnt = 16'h0000;
    repeat (cycles) begin
      @(posedge sys_clk);
      #1;
      if (irq === 1'b1) cnt++;
    end
  endtask

  task automatic check_regs();
    logic [15:0] addrs [5];
    addrs = '{ADDR_MODE, ADDR_CHAN, ADDR_CMP_MODE, ADDR_THRESHOLD, ADDR_RESULT};
    for (int k = 0; k < 5; k++) begin
      rdreg(addrs[k], rd);
      check("reset value", 16'(rd), 16'(REG_RESET));
    end
  endtask

  task automatic cmp_run(input logic [7:0] power_fail_mode, input logic [7:0] ch, input int exp);
    wr(ADDR_CMP_MODE, power_fail_mode);
    wr(ADDR_CHAN, ch);
    count_irq(600, n);
    check("compare irqs", n, 16'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    check_regs();
    wr(ADDR_THRESHOLD, 8'hA7);
    wr(16'hFF9C, 8'h3C);
    rdreg(ADDR_THRESHOLD, rd);
    check("threshold", 16'(rd), 16'h00A7);
    rdreg(16'hFF9C, rd);
    check("unmapped", 16'(rd), 16'(RDATA_UNMAPPED));
    // Every valid time code, channels 0-4 in turn, compare off
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CHAN, 8'(i % 5));
      wr(ADDR_MODE, {1'b1, 1'b0, codes[i], 3'b000});
      wait_irq(n);
      check("start latency", n, 16'(lens[i]));
      wait_irq(n);
      check("period", n, 16'(lens[i]));
      rdreg(ADDR_RESULT, rd);
      check("result", 16'(rd), 16'(levels[8*(i%5) +: 8]));
    end
    // Read colliding with a result update
    wait_irq(n);
    levels[7:0] = 8'h2B;
    repeat (CONV_CYC_192 - 2) @(posedge sys_clk);
    rdreg(ADDR_RESULT, rd);
    check("read priority", 16'(rd), 16'h0080);
    rdreg(ADDR_RESULT, rd);
    check("late result", 16'(rd), 16'h002B);
    // Channel write at the conversion-end edge
    wait_irq(n);
    repeat (CONV_CYC_192 - 2) @(posedge sys_clk);
    wr(ADDR_CHAN, 8'h01);
    #1;
    check("collision irq", 16'(irq), 16'h0000);
    wait_irq(n);
    check("restart", n, 16'(CONV_CYC_192));
    rdreg(ADDR_RESULT, rd);
    check("new channel", 16'(rd), 16'h003C);
    // Compare gating, long conversion time
    wr(ADDR_THRESHOLD, 8'h40);
    wr(ADDR_CMP_MODE, 8'h80);
    wr(ADDR_CHAN, 8'h02);
    wr(ADDR_MODE, {1'b0, 1'b0, TSEL_288, 3'b000});
    wr(ADDR_MODE, {1'b1, 1'b0, TSEL_288, 3'b000});
    count_irq(680, n);
    check("first suppressed", n, 16'h0001);
    cmp_run(8'hC0, 8'h02, 0);
    cmp_run(8'hC0, 8'h03, 2);
    cmp_run(8'h80, 8'h03, 0);
    wr(ADDR_THRESHOLD, 8'h01);
    cmp_run(8'h80, 8'h03, 2);
    // Stop in mid conversion
    repeat (50) @(posedge sys_clk);
    wr(ADDR_MODE, {1'b0, 1'b0, TSEL_288, 3'b000});
    @(posedge sys_clk);
    #1;
    check("stopped", {14'h0000, conv_active, sample_en}, 16'h0000);
    count_irq(400, n);
    check("no irq stopped", n, 16'h0000);
    // Reset in mid run
    wr(ADDR_MODE, {1'b1, 1'b0, TSEL_96, 3'b000});
    wait_irq(n);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    check_regs();
    results();
  end
endmodule
